// file: tg_window_masks.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - The power-down pulse begins at a 16-bit clock count within the sub-frame, reset 0.
// - The power-down pulse ends at a 16-bit clock count within the sub-frame, reset FFFF.
// - Bits 23:16 of both power-down registers are written as zero and always read zero.
// - The sequencer-interrupt mask holds last sub-frame in 23:12 and first in 11:0.
// - Each masked pulse passes only in sub-frames from its first to its last index.
// - The capture mask holds 12-bit last and first sub-frame indices, both reset 0.
// - The overload-window mask holds last sub-frame reset 0 and first sub-frame reset 1.
module tg_window_masks (
   // Clock and reset.
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   // Register port.
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [23:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [23:0] REG_RDATA,
   // Timing-generator boundaries.
   input  wire logic        SUBFRAME_START,
   input  wire logic        FRAME_START,
   // Raw pulses to be masked.
   input  wire logic        SEQ_IRQ_RAW,
   input  wire logic        CAPTURE_RAW,
   input  wire logic        OVERLOAD_RAW,
   // Shaped pulses.
   output logic             POWERDOWN_PULSE,
   output logic             SEQ_IRQ_PULSE,
   output logic             CAPTURE_PULSE,
   output logic             OVERLOAD_WINDOW
);

   typedef struct packed {
      logic [15:0] pd_begin;
      logic [15:0] pd_finish;
      logic [23:0] seq_mask;
      logic [23:0] cap_mask;
      logic [23:0] ovl_mask;
      logic [15:0] pd_begin_act;
      logic [15:0] pd_finish_act;
      logic [23:0] seq_act;
      logic [23:0] cap_act;
      logic [23:0] ovl_act;
      logic [15:0] clk_cnt;
      logic [11:0] sf_idx;
      logic [23:0] rdata;
   } tg_st_t;

   tg_st_t st_q;
   tg_st_t st_d;

   function automatic logic [23:0] reg_read(input tg_st_t s, input logic [7:0] a);
      logic [23:0] r;
      r = 24'h000000;
      unique case (a)
         tgmask_pkg::ADDR_PD_BEGIN:  r = {8'h00, s.pd_begin};
         tgmask_pkg::ADDR_PD_FINISH: r = {8'h00, s.pd_finish};
         tgmask_pkg::ADDR_SEQ_MASK:  r = s.seq_mask;
         tgmask_pkg::ADDR_CAP_MASK:  r = s.cap_mask;
         tgmask_pkg::ADDR_OVL_MASK:  r = s.ovl_mask;
         default:                    r = 24'h000000;
      endcase
      return r;
   endfunction

   function automatic logic [11:0] first_of(input logic [23:0] m);
      return m[tgmask_pkg::MASK_FIRST_LSB +: tgmask_pkg::SF_W];
   endfunction

   function automatic logic [11:0] last_of(input logic [23:0] m);
      return m[tgmask_pkg::MASK_LAST_LSB +: tgmask_pkg::SF_W];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      st_d = st_q;
      if (REG_WR) begin
         unique case (REG_ADDR)
            tgmask_pkg::ADDR_PD_BEGIN:  st_d.pd_begin  = REG_WDATA[15:0];
            tgmask_pkg::ADDR_PD_FINISH: st_d.pd_finish = REG_WDATA[15:0];
            tgmask_pkg::ADDR_SEQ_MASK:  st_d.seq_mask  = REG_WDATA;
            tgmask_pkg::ADDR_CAP_MASK:  st_d.cap_mask  = REG_WDATA;
            tgmask_pkg::ADDR_OVL_MASK:  st_d.ovl_mask  = REG_WDATA;
            default: ;
         endcase
      end
      if (REG_RD) begin
         st_d.rdata = reg_read(st_q, REG_ADDR);
      end
      // A frame start also opens a sub-frame, so both counters restart together.
      if (SUBFRAME_START || FRAME_START) begin
         st_d.clk_cnt       = 16'h0000;
         st_d.pd_begin_act  = st_q.pd_begin;
         st_d.pd_finish_act = st_q.pd_finish;
      end else if (st_q.clk_cnt != tgmask_pkg::CLK_CNT_MAX) begin
         st_d.clk_cnt = st_q.clk_cnt + 16'h0001;
      end
      if (FRAME_START) begin
         st_d.sf_idx  = 12'h000;
         st_d.seq_act = st_q.seq_mask;
         st_d.cap_act = st_q.cap_mask;
         st_d.ovl_act = st_q.ovl_mask;
      end else if (SUBFRAME_START && st_q.sf_idx != tgmask_pkg::SF_IDX_MAX) begin
         st_d.sf_idx = st_q.sf_idx + 12'h001;
      end
   end

   // Shadow copies make mid-pulse writes harmless; the cost is one boundary of latency.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_q               <= '0;
         st_q.pd_begin      <= tgmask_pkg::RST_PD_BEGIN;
         st_q.pd_finish     <= tgmask_pkg::RST_PD_FINISH;
         st_q.seq_mask      <= tgmask_pkg::RST_SEQ_MASK;
         st_q.cap_mask      <= tgmask_pkg::RST_CAP_MASK;
         st_q.ovl_mask      <= tgmask_pkg::RST_OVL_MASK;
         st_q.pd_begin_act  <= tgmask_pkg::RST_PD_BEGIN;
         st_q.pd_finish_act <= tgmask_pkg::RST_PD_FINISH;
         st_q.seq_act       <= tgmask_pkg::RST_SEQ_MASK;
         st_q.cap_act       <= tgmask_pkg::RST_CAP_MASK;
         st_q.ovl_act       <= tgmask_pkg::RST_OVL_MASK;
      end else begin
         st_q <= st_d;
      end
   end

   assign REG_RDATA = st_q.rdata;

   ////////////////////////////////////////////////////////////////////////////////

   span_gate #(.W(16), .INCL_END(1'b0)) u_pd (
      .clk     (CLK),
      .rst     (SYS_RST),
      .value   (st_q.clk_cnt),
      .first   (st_q.pd_begin_act),
      .last    (st_q.pd_finish_act),
      .gate    (1'b1),
      .pulse_q (POWERDOWN_PULSE)
   );

   span_gate #(.W(12), .INCL_END(1'b1)) u_seq (
      .clk     (CLK),
      .rst     (SYS_RST),
      .value   (st_q.sf_idx),
      .first   (first_of(st_q.seq_act)),
      .last    (last_of(st_q.seq_act)),
      .gate    (SEQ_IRQ_RAW),
      .pulse_q (SEQ_IRQ_PULSE)
   );

   span_gate #(.W(12), .INCL_END(1'b1)) u_cap (
      .clk     (CLK),
      .rst     (SYS_RST),
      .value   (st_q.sf_idx),
      .first   (first_of(st_q.cap_act)),
      .last    (last_of(st_q.cap_act)),
      .gate    (CAPTURE_RAW),
      .pulse_q (CAPTURE_PULSE)
   );

   span_gate #(.W(12), .INCL_END(1'b1)) u_ovl (
      .clk     (CLK),
      .rst     (SYS_RST),
      .value   (st_q.sf_idx),
      .first   (first_of(st_q.ovl_act)),
      .last    (last_of(st_q.ovl_act)),
      .gate    (OVERLOAD_RAW),
      .pulse_q (OVERLOAD_WINDOW)
   );

   ////////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   a_pd_in_range: assert property (POWERDOWN_PULSE |->
      ($past(st_q.clk_cnt) >= $past(st_q.pd_begin_act)) &&
      ($past(st_q.clk_cnt) < $past(st_q.pd_finish_act)))
      else $error("Power-down pulse outside its span.");

   a_pd_fires_inside: assert property (
      (st_q.clk_cnt >= st_q.pd_begin_act && st_q.clk_cnt < st_q.pd_finish_act)
      |=> POWERDOWN_PULSE)
      else $error("Power-down pulse missing inside its span.");

   a_pd_reserved_zero: assert property (
      REG_RD && (REG_ADDR == 8'h93 || REG_ADDR == 8'h94) |=> REG_RDATA[23:16] == 8'h00)
      else $error("Reserved power-down bits read nonzero.");

   a_clk_cnt_restart: assert property (
      (SUBFRAME_START || FRAME_START) |=> st_q.clk_cnt == 16'h0000 ##1
      (st_q.clk_cnt == 16'h0001 || $past(SUBFRAME_START || FRAME_START)))
      else $error("Clock counter did not restart at sub-frame.");

   a_sf_idx_step: assert property (
      SUBFRAME_START && !FRAME_START && st_q.sf_idx != 12'hFFF
      |=> st_q.sf_idx == $past(st_q.sf_idx) + 12'h001)
      else $error("Sub-frame index did not advance.");

   a_seq_masked: assert property (SEQ_IRQ_PULSE |->
      $past(SEQ_IRQ_RAW) && $past(st_q.sf_idx) >= $past(st_q.seq_act[11:0]) &&
      $past(st_q.sf_idx) <= $past(st_q.seq_act[23:12]))
      else $error("Sequencer pulse outside its mask.");

   a_cap_masked: assert property (CAPTURE_PULSE |->
      $past(CAPTURE_RAW) && $past(st_q.sf_idx) >= $past(st_q.cap_act[11:0]) &&
      $past(st_q.sf_idx) <= $past(st_q.cap_act[23:12]))
      else $error("Capture pulse outside its mask.");

   a_ovl_masked: assert property (OVERLOAD_WINDOW |->
      $past(OVERLOAD_RAW) && $past(st_q.sf_idx) >= $past(st_q.ovl_act[11:0]) &&
      $past(st_q.sf_idx) <= $past(st_q.ovl_act[23:12]))
      else $error("Overload window outside its mask.");

   a_shadow_hold: assert property (
      !SUBFRAME_START && !FRAME_START |=> $stable(st_q.pd_begin_act) &&
      $stable(st_q.pd_finish_act) && $stable(st_q.seq_act))
      else $error("Active position changed away from a boundary.");

endmodule // tg_window_masks

// file: tgmask_pkg.sv
package tgmask_pkg;

   // Register indices on the device register port.
   localparam logic [7:0]  ADDR_PD_BEGIN      = 8'h93;
   localparam logic [7:0]  ADDR_PD_FINISH     = 8'h94;
   localparam logic [7:0]  ADDR_SEQ_MASK      = 8'h97;
   localparam logic [7:0]  ADDR_CAP_MASK      = 8'h98;
   localparam logic [7:0]  ADDR_OVL_MASK      = 8'h99;

   // Field layout.
   localparam int          REG_W              = 24;
   localparam int          POS_W              = 16;
   localparam int          SF_W               = 12;
   localparam int          MASK_LAST_LSB      = 12;
   localparam int          MASK_FIRST_LSB     = 0;

   // Values after reset.
   localparam logic [15:0] RST_PD_BEGIN       = 16'h0000;
   localparam logic [15:0] RST_PD_FINISH      = 16'hFFFF;
   localparam logic [23:0] RST_SEQ_MASK       = 24'h000000;
   localparam logic [23:0] RST_CAP_MASK       = 24'h000000;
   localparam logic [23:0] RST_OVL_MASK       = 24'h000001;

   // Counter limits.
   localparam logic [15:0] CLK_CNT_MAX        = 16'hFFFF;
   localparam logic [11:0] SF_IDX_MAX         = 12'hFFF;

endpackage

// file: span_gate.sv
`timescale 1ns/1ps

module span_gate #(
   parameter int W        = 16,
   parameter bit INCL_END = 1'b1
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst,
   // Position and window.
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] first,
   input  wire logic [W-1:0] last,
   input  wire logic         gate,
   // Gated pulse.
   output logic              pulse_q
);

   typedef struct packed {
      logic pulse;
   } gate_st_t;

   gate_st_t st_q;
   gate_st_t st_d;

   always_comb begin
      st_d       = st_q;
      st_d.pulse = gate && (value >= first) &&
                   (INCL_END ? (value <= last) : (value < last));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pulse_q = st_q.pulse;

endmodule // span_gate

// file: tg_window_masks_tb.sv
`timescale 1ns/1ps

module tg_window_masks_tb;
   logic        CLK            = 1'b0;
   logic        SYS_RST        = 1'b1;
   logic [7:0]  REG_ADDR       = 8'h00;
   logic [23:0] REG_WDATA      = 24'h000000;
   logic        REG_WR         = 1'b0;
   logic        REG_RD         = 1'b0;
   logic        SUBFRAME_START = 1'b0;
   logic        FRAME_START    = 1'b0;
   logic [2:0]  raw            = 3'h0;
   logic        probe          = 1'b0;
   logic [23:0] REG_RDATA;
   logic        POWERDOWN_PULSE;
   logic        SEQ_IRQ_PULSE;
   logic        CAPTURE_PULSE;
   logic        OVERLOAD_WINDOW;
   logic [23:0] notes[$];
   logic        seen_rd;
   logic        seen_pr;
   logic [2:0]  r;
   logic [11:0] sq_first;
   logic [11:0] sq_last;
   logic [5:0]  pat            = 6'b000110;
   int          n_mismatch     = 0;
   int          checked        = 0;

   always #25 CLK = ~CLK;

   tg_window_masks tg_window_masks_inst (
      .CLK             (CLK),
      .SYS_RST         (SYS_RST),
      .REG_ADDR        (REG_ADDR),
      .REG_WDATA       (REG_WDATA),
      .REG_WR          (REG_WR),
      .REG_RD          (REG_RD),
      .REG_RDATA       (REG_RDATA),
      .SUBFRAME_START  (SUBFRAME_START),
      .FRAME_START     (FRAME_START),
      .SEQ_IRQ_RAW     (raw[2]),
      .CAPTURE_RAW     (raw[1]),
      .OVERLOAD_RAW    (raw[0]),
      .POWERDOWN_PULSE (POWERDOWN_PULSE),
      .SEQ_IRQ_PULSE   (SEQ_IRQ_PULSE),
      .CAPTURE_PULSE   (CAPTURE_PULSE),
      .OVERLOAD_WINDOW (OVERLOAD_WINDOW)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("TB: %0d checks, %0d mismatches", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic compare(input logic [23:0] got);
      logic [23:0] exp;
      if (notes.size() == 0) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got 0x%h expected 0x(none)", $time, got);
      end else begin
         exp = notes.pop_front();
         checked++;
         if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got 0x%h expected 0x%h", $time, got, exp);
         end
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(negedge CLK);
      probe = 1'b0;
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      @(negedge CLK);
      REG_WR = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [23:0] e);
      @(negedge CLK);
      probe = 1'b0;
      REG_ADDR = a;
      REG_RD = 1'b1;
      notes.push_back(e);
      @(negedge CLK);
      REG_RD = 1'b0;
   endtask

   // A probe cycle notes what the four shaped outputs must show after the next edge.
   task automatic tick(input logic sf, input logic fs, input logic pr, input logic [3:0] e);
      @(negedge CLK);
      SUBFRAME_START = sf;
      FRAME_START = fs;
      probe = pr;
      if (pr) begin
         notes.push_back({20'h00000, e});
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Results are judged a little after the edge so that registered outputs have landed.
   always @(posedge CLK) begin
      seen_rd = REG_RD;
      seen_pr = probe;
      #10;
      if (seen_rd) begin
         compare(REG_RDATA);
      end
      if (seen_pr) begin
         compare({20'h00000, POWERDOWN_PULSE, SEQ_IRQ_PULSE, CAPTURE_PULSE, OVERLOAD_WINDOW});
      end
   end

   initial begin
      repeat (5000) @(posedge CLK);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      void'($urandom(32'h4bb1b994));
      repeat (4) @(posedge CLK);
      @(negedge CLK);
      SYS_RST = 1'b0;
      rd(tgmask_pkg::ADDR_PD_BEGIN, 24'h000000);
      rd(tgmask_pkg::ADDR_PD_FINISH, 24'h00FFFF);
      rd(tgmask_pkg::ADDR_SEQ_MASK, 24'h000000);
      rd(tgmask_pkg::ADDR_CAP_MASK, 24'h000000);
      rd(tgmask_pkg::ADDR_OVL_MASK, 24'h000001);
      wr(8'h96, 24'hFFFFFF);
      rd(8'h96, 24'h000000);
      wr(tgmask_pkg::ADDR_PD_BEGIN, 24'hFF0002);
      wr(tgmask_pkg::ADDR_PD_FINISH, 24'hAB0004);
      rd(tgmask_pkg::ADDR_PD_BEGIN, 24'h000002);
      rd(tgmask_pkg::ADDR_PD_FINISH, 24'h000004);
      tick(1'b0, 1'b0, 1'b1, 4'h8);
      $display("TB: register test done");
      for (int s = 0; s < 2; s++) begin
         tick(s == 0, s == 1, 1'b0, 4'h0);
         tick(1'b0, 1'b0, 1'b0, 4'h0);
         for (int i = 0; i < 6; i++) begin
            tick(1'b0, 1'b0, 1'b1, {pat[i], 3'b000});
         end
      end
      $display("TB: power-down test done");
      wr(tgmask_pkg::ADDR_PD_FINISH, 24'h000000);
      wr(tgmask_pkg::ADDR_SEQ_MASK, 24'h002001);
      wr(tgmask_pkg::ADDR_CAP_MASK, 24'h003003);
      wr(tgmask_pkg::ADDR_OVL_MASK, 24'h003001);
      rd(tgmask_pkg::ADDR_OVL_MASK, 24'h003001);
      rd(tgmask_pkg::ADDR_SEQ_MASK, 24'h002001);
      sq_first = 12'h001;
      sq_last = 12'h002;
      for (int f = 0; f < 2; f++) begin
         for (int k = 0; k < 6; k++) begin
            if (f == 0 && k == 3) begin
               wr(tgmask_pkg::ADDR_SEQ_MASK, 24'h005005);
            end
            r = 3'($urandom_range(7));
            tick(1'b1, k == 0, 1'b0, 4'h0);
            raw = r;
            tick(1'b0, 1'b0, 1'b0, 4'h0);
            tick(1'b0, 1'b0, 1'b1, {1'b0, r[2] & (k >= sq_first && k <= sq_last),
                 r[1] & (k == 3), r[0] & (k >= 1 && k <= 3)});
         end
         sq_first = 12'h005;
         sq_last = 12'h005;
      end
      tick(1'b0, 1'b0, 1'b0, 4'h0);
      repeat (3) @(negedge CLK);
      $display("TB: mask test done");
      if (notes.size() != 0) begin
         n_mismatch++;
      end
      report_and_stop();
   end
endmodule // tg_window_masks_tb
